// ### logic/scab_pkg.sv
package scab_pkg;

  // clock period and printed bus delays, in nanoseconds
  localparam int CLK_NS = 10;
  localparam int T_ARB_NS = 2400;
  localparam int T_ASSERT_NS = 90;
  localparam int T_CLEAR_NS = 800;
  localparam int T_FREE_NS = 800;
  localparam int T_SET_NS = 1800;
  localparam int T_SETTLE_NS = 400;
  localparam int T_DESKEW_NS = 45;
  localparam int T_DISC_NS = 200000;
  localparam int T_HOLD_NS = 45;
  localparam int T_NEG_NS = 90;
  localparam int T_RST_HOLD_NS = 200000;
  localparam int T_ABORT_NS = 200000;
  localparam int T_SELTO_NS = 250000000;

  // least times round up, longest times round down
  localparam int ARB_CYC = (T_ARB_NS + CLK_NS - 1) / CLK_NS;
  localparam int ASSERT_CYC = (T_ASSERT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLEAR_CYC = T_CLEAR_NS / CLK_NS;
  localparam int FREE_CYC = (T_FREE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SET_CYC = T_SET_NS / CLK_NS;
  localparam int SETTLE_CYC = (T_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DESKEW2_CYC = (2 * T_DESKEW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int NEG_CYC = (T_NEG_NS + CLK_NS - 1) / CLK_NS;
  localparam int DISC_CYC = (T_DISC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_HOLD_CYC = (T_RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ABORT_CYC = T_ABORT_NS / CLK_NS;
  localparam int SELTO_CYC = (T_SELTO_NS + CLK_NS - 1) / CLK_NS;

  // counter widths
  localparam int AGE_W = 25;
  localparam int REQ_W = 8;
  localparam int QUIET_W = 8;

  // one bit per bus line, true means asserted
  typedef struct packed {
    logic bsy;
    logic sel;
    logic rst;
    logic atn;
    logic io;
    logic cd;
    logic msg;
    logic req;
    logic ack;
    logic dbp;
    logic [7:0] db;
  } scab_bus_t;

  // information phase lines chosen by the user side
  typedef struct packed {
    logic msg;
    logic cd;
    logic io;
  } scab_phase_t;

endpackage

// ### logic/scab_age.sv
`timescale 1ns/10ps
`default_nettype none

module scab_age #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clr,
  output logic [W-1:0] count
);

  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;

  // saturates so a long wait never wraps back to a short one
  assign nxt_count = clr ? '0 : ((&count_ff) ? count_ff : count_ff + W'(1));
  assign count = count_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

endmodule

`default_nettype wire

// ### logic/scab_free_det.sv
`timescale 1ns/10ps
`default_nettype none

module scab_free_det
  import scab_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic bsy_s,
  input wire logic sel_s,
  output logic bus_free
);

  logic [QUIET_W-1:0] quiet_ff;
  logic [QUIET_W-1:0] nxt_quiet;
  logic quiet_now;

  // both lines must stay false without a break
  assign quiet_now = !bsy_s && !sel_s;
  assign nxt_quiet = !quiet_now ? '0 : ((&quiet_ff) ? quiet_ff : quiet_ff + QUIET_W'(1));
  assign bus_free = quiet_ff >= QUIET_W'(SETTLE_CYC); // RULE11

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      quiet_ff <= '0;
    end else begin
      quiet_ff <= nxt_quiet;
    end
  end

endmodule

`default_nettype wire

// ### logic/scab_target.sv
// Contract
// RULE1: arbitration drive of busy and own id starts within bus set delay of free
// RULE2: initiator releases data lines within data release delay after io rises
// RULE3: after a disconnect wait the disconnection delay before arbitrating again
// RULE4: data lines stay unchanged at least the hold time after a strobe
// RULE5: each sync strobe negation lasts at least the negation period
// RULE6: a driven bus reset lasts at least the reset hold time
// RULE7: busy answer to selection comes inside the abort window, never later
// RULE8: a selector waits at least the selection time-out for busy
// RULE9: sync strobe leading edges are spaced at least the transfer period
// RULE10: only one phase at a time; lines not called for stay released
// RULE11: bus free only after select and busy are false a settle delay
// RULE12: release all lines within clear delay once bus free is seen
// RULE13: target may drop busy to flag an error and abort the nexus
// RULE14: wait bus free delay after free, then assert busy with own id
// RULE15: abandon arbitration if free was last seen over a settle delay ago
// RULE16: after arbitration delay sample data; no higher id means win
// RULE17: a loser releases busy and id within clear delay of select
// RULE18: the winner holds every line for clear plus settle delay
// RULE19: a selector keeps io low, drives both ids and raises attention
// RULE20: selector releases busy after two deskews, then waits a settle delay
// RULE21: ignore selection with bad parity or more than two ids set
// RULE22: no request strobe until the select line has gone false
// RULE23: clear delay is 800 ns; clearing after free within 1200 ns
// RULE24: bus free delay is 800 ns
// RULE25: arbitration delay is 2.4 us with no maximum
// RULE26: every bus delay is a cycle count derived from the clock rate
`timescale 1ns/10ps
`default_nettype none

module scab_target #(
  parameter int DISC_LIM = scab_pkg::DISC_CYC,
  parameter int ABORT_LIM = scab_pkg::ABORT_CYC,
  parameter int RST_HOLD_LIM = scab_pkg::RST_HOLD_CYC,
  parameter int SELTO_LIM = scab_pkg::SELTO_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire scab_pkg::scab_bus_t bus_in,
  output scab_pkg::scab_bus_t bus_out,
  output scab_pkg::scab_bus_t bus_oe,
  input wire logic [2:0] my_id,
  input wire logic sel_enable,
  input wire logic resel_req,
  input wire logic [2:0] init_id,
  input wire logic disc_req,
  input wire logic err_drop,
  input wire logic bus_reset_req,
  input wire scab_pkg::scab_phase_t phase_in,
  input wire logic req_go,
  input wire logic [7:0] tx_byte,
  input wire logic sync_en,
  input wire logic [7:0] xfer_cyc,
  output logic selected,
  output logic resel_ok,
  output logic resel_fail,
  output logic arb_lost,
  output logic nexus_abort,
  output logic connected,
  output logic req_ready,
  output logic bus_reset_seen,
  output logic [7:0] sel_ids
);
  import scab_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_FREE_WAIT, S_ARB, S_WIN_HOLD, S_RESEL_DRIVE, S_RESEL_WAIT,
    S_RESEL_BSY, S_SEL_RESP, S_CONN, S_DISC, S_RST_DRIVE
  } scab_state_t;

  scab_state_t state_ff, nxt_state;
  scab_bus_t sync1_ff, bus_s;
  scab_bus_t out_ff, nxt_out, oe_ff, nxt_oe;
  logic [AGE_W-1:0] age;
  logic [REQ_W-1:0] rise_age, low_age;
  logic bus_free, age_clr;
  logic disc_hold_ff, nxt_disc_hold;
  logic req_ff, nxt_req;
  logic [7:0] db_out_ff, nxt_db_out;
  scab_phase_t phase_ff, nxt_phase;
  logic [7:0] sel_ids_ff;
  logic sel_pulse_ff, resel_ok_ff, resel_fail_ff, lost_ff, abort_ff;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= '0;
      bus_s <= '0;
    end else begin
      sync1_ff <= bus_in;
      bus_s <= sync1_ff;
    end
  end

  scab_free_det u_free (
    .core_clk(core_clk),
    .rst(rst),
    .bsy_s(bus_s.bsy),
    .sel_s(bus_s.sel),
    .bus_free(bus_free)
  );

  // cycles spent in the present state
  assign age_clr = (nxt_state != state_ff);
  scab_age #(.W(AGE_W)) u_state_age (
    .core_clk(core_clk),
    .rst(rst),
    .clr(age_clr),
    .count(age)
  );

  // id decode and selection qualification
  wire [7:0] own_bit = 8'h01 << my_id;
  wire [7:0] init_bit = 8'h01 << init_id;
  wire [7:0] higher_mask = ~((own_bit << 1) - 8'h01); // bits above our own id
  wire parity_ok = ^{bus_s.db, bus_s.dbp}; // odd parity over nine lines
  wire id_count_ok = ($countones(bus_s.db) <= 2);
  wire sel_seen = bus_s.sel && !bus_s.bsy && !bus_s.io && ((bus_s.db & own_bit) != 8'h00);
  wire sel_valid = sel_enable && sel_seen && parity_ok && id_count_ok; // RULE21
  wire higher_won = ((bus_s.db & higher_mask) != 8'h00); // RULE16
  wire ext_reset = bus_s.rst && !oe_ff.rst;
  wire arb_allowed = resel_req && bus_free && !disc_hold_ff;

  // phase sequencer
  always_comb begin
    nxt_state = state_ff;
    if (ext_reset) begin
      nxt_state = S_IDLE; // RULE12
    end else begin
      unique case (state_ff)
        S_IDLE: begin
          if (bus_reset_req) begin
            nxt_state = S_RST_DRIVE;
          end else if (sel_valid) begin
            nxt_state = S_SEL_RESP; // RULE7
          end else if (arb_allowed) begin
            nxt_state = S_FREE_WAIT;
          end
        end
        S_FREE_WAIT: begin
          if (!bus_free) begin
            nxt_state = S_IDLE; // RULE15
          end else if (age >= AGE_W'(FREE_CYC - 1)) begin
            nxt_state = S_ARB; // RULE14 RULE1 RULE24
          end
        end
        S_ARB: begin
          if (bus_s.sel) begin
            nxt_state = S_IDLE; // RULE17
          end else if (age >= AGE_W'(ARB_CYC)) begin
            nxt_state = higher_won ? S_IDLE : S_WIN_HOLD; // RULE16 RULE25
          end
        end
        S_WIN_HOLD: begin
          if (age >= AGE_W'(CLEAR_CYC + SETTLE_CYC)) begin
            nxt_state = S_RESEL_DRIVE; // RULE18
          end
        end
        S_RESEL_DRIVE: begin
          if (age >= AGE_W'(DESKEW2_CYC)) begin
            nxt_state = S_RESEL_WAIT;
          end
        end
        S_RESEL_WAIT: begin
          if (age >= AGE_W'(SETTLE_CYC) && bus_s.bsy) begin
            nxt_state = S_RESEL_BSY;
          end else if (age >= AGE_W'(SELTO_LIM)) begin
            nxt_state = S_IDLE; // RULE8
          end
        end
        S_RESEL_BSY: begin
          if (age >= AGE_W'(DESKEW2_CYC)) begin
            nxt_state = S_CONN;
          end
        end
        S_SEL_RESP: begin
          if (!bus_s.sel) begin
            nxt_state = S_CONN; // RULE22
          end
        end
        S_CONN: begin
          if (err_drop || disc_req) begin
            nxt_state = S_DISC; // RULE13
          end
        end
        S_DISC: begin
          if (!disc_hold_ff || age >= AGE_W'(DISC_LIM - 1)) begin
            nxt_state = S_IDLE; // RULE3
          end
        end
        S_RST_DRIVE: begin
          if (age >= AGE_W'(RST_HOLD_LIM - 1)) begin
            nxt_state = S_IDLE; // RULE6
          end
        end
      endcase
    end
  end

  // disconnect guard is set on a clean disconnect only
  assign nxt_disc_hold = (state_ff == S_CONN && disc_req && !err_drop) ? 1'b1 :
                         (state_ff == S_DISC) ? disc_hold_ff : 1'b0;

  // request strobe pacing in the connected phase
  wire in_conn = (state_ff == S_CONN) && (nxt_state == S_CONN);
  wire [REQ_W-1:0] space_min = (xfer_cyc > REQ_W'(ASSERT_CYC + NEG_CYC)) ?
                               xfer_cyc : REQ_W'(ASSERT_CYC + NEG_CYC);
  wire sync_ok = (low_age >= REQ_W'(NEG_CYC)) && (rise_age >= space_min); // RULE5 RULE9
  wire async_ok = !bus_s.ack;
  assign req_ready = in_conn && !req_ff && !bus_s.sel && (sync_en ? sync_ok : async_ok); // RULE22
  wire req_rise = req_ready && req_go;
  wire req_end = sync_en ? (rise_age >= REQ_W'(ASSERT_CYC - 1)) : bus_s.ack;
  assign nxt_req = !in_conn ? 1'b0 : (req_rise ? 1'b1 : (req_ff && !req_end));
  // data only changes at a new leading edge, far past the hold time
  assign nxt_db_out = req_rise ? tx_byte : db_out_ff; // RULE4
  // phase lines stay put while a strobe is out so they envelope it
  assign nxt_phase = (in_conn && !req_ff && !req_rise) ? phase_in : phase_ff;

  scab_age #(.W(REQ_W)) u_rise_age (
    .core_clk(core_clk),
    .rst(rst),
    .clr(req_rise),
    .count(rise_age)
  );

  scab_age #(.W(REQ_W)) u_low_age (
    .core_clk(core_clk),
    .rst(rst),
    .clr(req_ff),
    .count(low_age)
  );

  // line drive per state; anything not listed stays released
  always_comb begin
    nxt_oe = '0;
    nxt_out = '0;
    unique case (nxt_state)
      S_ARB: begin
        nxt_oe.bsy = 1'b1;
        nxt_oe.db = own_bit;
      end
      S_WIN_HOLD: begin
        nxt_oe.bsy = 1'b1;
        nxt_oe.sel = 1'b1;
        nxt_oe.db = own_bit;
      end
      S_RESEL_DRIVE, S_RESEL_BSY: begin
        nxt_oe.bsy = 1'b1;
        nxt_oe.sel = 1'b1;
        nxt_oe.io = 1'b1;
        nxt_oe.db = 8'hFF;
        nxt_oe.dbp = 1'b1;
      end
      S_RESEL_WAIT: begin
        nxt_oe.sel = 1'b1;
        nxt_oe.io = 1'b1;
        nxt_oe.db = 8'hFF;
        nxt_oe.dbp = 1'b1;
      end
      S_SEL_RESP: begin
        nxt_oe.bsy = 1'b1;
      end
      S_CONN: begin
        nxt_oe.bsy = 1'b1;
        nxt_oe.msg = 1'b1;
        nxt_oe.cd = 1'b1;
        nxt_oe.io = 1'b1;
        nxt_oe.req = 1'b1;
        nxt_oe.db = {8{phase_ff.io}};
        nxt_oe.dbp = phase_ff.io;
      end
      S_RST_DRIVE: begin
        nxt_oe.rst = 1'b1;
      end
      default: begin
        nxt_oe = '0; // RULE10 RULE12 RULE23
      end
    endcase
    nxt_out.bsy = 1'b1;
    nxt_out.sel = 1'b1;
    nxt_out.rst = 1'b1;
    nxt_out.msg = phase_ff.msg;
    nxt_out.cd = phase_ff.cd;
    nxt_out.io = (nxt_state == S_CONN) ? phase_ff.io : 1'b1;
    nxt_out.req = nxt_req;
    nxt_out.db = (nxt_state == S_CONN) ? nxt_db_out :
                 (nxt_oe.sel && nxt_oe.io) ? (own_bit | init_bit) : own_bit;
    nxt_out.dbp = ~^nxt_out.db;
  end

  // main registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
      out_ff <= '0;
      oe_ff <= '0;
      disc_hold_ff <= 1'b0;
      req_ff <= 1'b0;
      db_out_ff <= 8'h00;
      phase_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      disc_hold_ff <= nxt_disc_hold;
      req_ff <= nxt_req;
      db_out_ff <= nxt_db_out;
      phase_ff <= nxt_phase;
    end
  end

  // user-side event pulses and captured ids
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_pulse_ff <= 1'b0;
      resel_ok_ff <= 1'b0;
      resel_fail_ff <= 1'b0;
      lost_ff <= 1'b0;
      abort_ff <= 1'b0;
      sel_ids_ff <= 8'h00;
    end else begin
      sel_pulse_ff <= (state_ff == S_IDLE) && (nxt_state == S_SEL_RESP);
      resel_ok_ff <= (state_ff == S_RESEL_BSY) && (nxt_state == S_CONN);
      resel_fail_ff <= (state_ff == S_RESEL_WAIT) && (nxt_state == S_IDLE);
      lost_ff <= (state_ff == S_ARB) && (nxt_state == S_IDLE);
      abort_ff <= (state_ff == S_CONN) && err_drop; // RULE13
      if ((state_ff == S_IDLE) && (nxt_state == S_SEL_RESP)) begin
        sel_ids_ff <= bus_s.db;
      end
    end
  end

  assign bus_out = out_ff;
  assign bus_oe = oe_ff;
  assign selected = sel_pulse_ff;
  assign resel_ok = resel_ok_ff;
  assign resel_fail = resel_fail_ff;
  assign arb_lost = lost_ff;
  assign nexus_abort = abort_ff;
  assign connected = (state_ff == S_CONN);
  assign bus_reset_seen = bus_s.rst;
  assign sel_ids = sel_ids_ff;

  chk_idle_release: assert property (@(posedge core_clk) disable iff (rst) // RULE12
    (state_ff == S_IDLE) |-> (bus_oe == '0))
    else $error("lines driven while idle");

  chk_arb_entry: assert property (@(posedge core_clk) disable iff (rst) // RULE14
    (state_ff == S_FREE_WAIT && nxt_state == S_ARB) |->
      bus_free && age >= AGE_W'(FREE_CYC - 1) && age < AGE_W'(SET_CYC) ##1
      bus_oe.bsy && bus_oe.db == own_bit)
    else $error("arbitration drive outside free window");

  chk_arb_sample: assert property (@(posedge core_clk) disable iff (rst) // RULE16
    (state_ff == S_ARB && nxt_state == S_WIN_HOLD) |-> age >= AGE_W'(ARB_CYC) && !higher_won)
    else $error("arbitration decided early or wrongly");

  chk_lose_release: assert property (@(posedge core_clk) disable iff (rst) // RULE17
    (state_ff == S_ARB && bus_s.sel) |=> (bus_oe == '0))
    else $error("loser kept driving after select");

  chk_win_stable: assert property (@(posedge core_clk) disable iff (rst) // RULE18
    (state_ff == S_WIN_HOLD && $past(state_ff) == S_WIN_HOLD) |->
      $stable(bus_oe) && $stable(bus_out))
    else $error("winner changed lines during hold");

  chk_disc_delay: assert property (@(posedge core_clk) disable iff (rst) // RULE3
    (state_ff == S_DISC && disc_hold_ff && nxt_state == S_IDLE && !ext_reset) |->
      age >= AGE_W'(DISC_LIM - 1))
    else $error("disconnect delay cut short");

  chk_sel_answer: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    (state_ff == S_IDLE && nxt_state == S_SEL_RESP) |=> bus_oe.bsy ##1 bus_oe.bsy)
    else $error("busy answer to selection missing");

  chk_sel_ignore: assert property (@(posedge core_clk) disable iff (rst) // RULE21
    (state_ff == S_IDLE && (!parity_ok || !id_count_ok)) |=> state_ff != S_SEL_RESP)
    else $error("bad selection was answered");

  chk_req_gap: assert property (@(posedge core_clk) disable iff (rst) // RULE22
    $rose(bus_out.req) |-> $past(!bus_s.sel) &&
      (!$past(sync_en) || $past(low_age) >= REQ_W'(NEG_CYC)))
    else $error("request raised too soon");

  chk_rst_hold: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    $fell(bus_oe.rst) |-> $past(age) >= AGE_W'(RST_HOLD_LIM - 1) || ext_reset)
    else $error("bus reset released early");

endmodule

`default_nettype wire

// ### verification/scab_init_model.sv
`timescale 1ns/10ps
`default_nettype none

module scab_init_model #(
  parameter int ID_BIT = 6
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire scab_pkg::scab_bus_t bus,
  input wire logic sel_go,
  input wire logic [7:0] sel_db,
  input wire logic bad_par,
  input wire logic mute,
  output var logic done,
  output scab_pkg::scab_bus_t m_out,
  output var scab_pkg::scab_bus_t m_oe
);
  import scab_pkg::*;

  logic [7:0] db_v;
  logic dbp_v;

  // control lines read true when enabled; released lines fall to the terminator level
  assign m_out = {9'h1FF, dbp_v, db_v};

  // unopposed arbitration, then selection of the target named in sel_db
  task automatic do_sel();
    int w;
    done <= 1'b0;
    db_v <= 8'h01 << ID_BIT;
    m_oe.db <= 8'h01 << ID_BIT;
    m_oe.bsy <= 1'b1;
    repeat (240) @(posedge core_clk);
    m_oe.sel <= 1'b1;
    repeat (120) @(posedge core_clk);
    db_v <= sel_db;
    dbp_v <= ~(^sel_db) ^ bad_par;
    m_oe.db <= 8'hFF;
    m_oe.dbp <= 1'b1;
    m_oe.atn <= 1'b1;
    repeat (9) @(posedge core_clk);
    m_oe.bsy <= 1'b0;
    repeat (40) @(posedge core_clk);
    // wait shortened from the recommended time-out to keep the run short
    for (w = 0; w < 300 && bus.bsy !== 1'b1; w++) @(posedge core_clk);
    repeat (9) @(posedge core_clk);
    m_oe <= '0;
    done <= 1'b1;
  endtask

  // reselection answer and acknowledge follow the raw bus
  initial begin
    m_oe = '0;
    db_v = 8'h00;
    dbp_v = 1'b0;
    done = 1'b1;
    forever begin
      @(posedge core_clk);
      if (rst) m_oe <= '0;
      else if (sel_go) do_sel();
      else if (bus.sel && bus.io && bus.db[ID_BIT] && !bus.bsy && !mute) m_oe.bsy <= 1'b1;
      else if (!bus.sel) m_oe.bsy <= 1'b0;
      m_oe.ack <= bus.req && !rst;
    end
  end
endmodule

`default_nettype wire

// ### verification/scsi_arbitration_selection_bench.sv
`timescale 1ns/10ps
`default_nettype none

module scsi_arbitration_selection_bench;
  import scab_pkg::*;

  localparam int DISC = 300;
  logic core_clk, rst, sel_go, bad_par, mute, mdone, sel_enable, resel_req, disc_req;
  logic err_drop, bus_reset_req, req_go, sync_en, selected, resel_ok, resel_fail;
  logic arb_lost, nexus_abort, connected, req_ready, rst_seen;
  logic [2:0] my_id, init_id;
  logic [7:0] tx_byte, xfer_cyc, sel_db, sel_ids, ids;
  logic [31:0] seed;
  scab_phase_t phase_in;
  scab_bus_t bus, t_out, t_oe, m_out, m_oe, x_drv;
  int mismatches = 0, num_checks = 0, cyc = 0, n_sel = 0, n_ok = 0, n_fail = 0;
  int n_lost = 0, n_abort = 0, i, k, k0;

  // wired bus: a line is true when any party drives it true
  assign bus = (t_out & t_oe) | (m_out & m_oe) | x_drv;

  scab_target #(.DISC_LIM(DISC), .ABORT_LIM(50), .RST_HOLD_LIM(30), .SELTO_LIM(200))
  i_scab_target (
    .core_clk(core_clk), .rst(rst), .bus_in(bus), .bus_out(t_out), .bus_oe(t_oe),
    .my_id(my_id), .sel_enable(sel_enable), .resel_req(resel_req), .init_id(init_id),
    .disc_req(disc_req), .err_drop(err_drop), .bus_reset_req(bus_reset_req),
    .phase_in(phase_in), .req_go(req_go), .tx_byte(tx_byte), .sync_en(sync_en),
    .xfer_cyc(xfer_cyc), .selected(selected), .resel_ok(resel_ok), .resel_fail(resel_fail),
    .arb_lost(arb_lost), .nexus_abort(nexus_abort), .connected(connected),
    .req_ready(req_ready), .bus_reset_seen(rst_seen), .sel_ids(sel_ids));

  scab_init_model #(.ID_BIT(6)) i_scab_init_model (
    .core_clk(core_clk), .rst(rst), .bus(bus), .sel_go(sel_go), .sel_db(sel_db),
    .bad_par(bad_par), .mute(mute), .done(mdone), .m_out(m_out), .m_oe(m_oe));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // pulse tallies and the hang limit
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    n_sel <= n_sel + int'(selected === 1'b1);
    n_ok <= n_ok + int'(resel_ok === 1'b1);
    n_fail <= n_fail + int'(resel_fail === 1'b1);
    n_lost <= n_lost + int'(arb_lost === 1'b1);
    n_abort <= n_abort + int'(nexus_abort === 1'b1);
    if (cyc == 40000) begin
      mismatches++;
      summarize();
    end
  end

  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // answer only with own bit, at most two ids and odd parity
  function automatic logic exp_sel(input logic [7:0] d, input logic bad);
    return d[my_id] && ($countones(d) <= 2) && !bad;
  endfunction

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic note(input string s);
    $display("test %s finished", s);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // inputs change on the falling edge only
  initial begin
    seed = 32'd26796;
    {sel_go, bad_par, mute, resel_req, disc_req, err_drop, bus_reset_req, req_go} = '0;
    {sync_en, tx_byte, sel_db} = '0;
    sel_enable = 1'b1;
    my_id = 3'h2;
    init_id = 3'h6;
    xfer_cyc = 8'h12;
    phase_in = '0;
    x_drv = '0;
    rst = 1'b1;
    tick(16);
    rst = 1'b0;
    tick(1);
    chk(t_oe === '0 && connected === 1'b0, "bus not released after reset");
    note("reset");
    // selections: good, three ids, bad parity, four random ones, then a good one
    for (i = 0; i < 8; i++) begin
      ids = (i == 1) ? 8'h46 : (i < 3 || i == 7) ? 8'h44 : rnd8() & rnd8() & rnd8();
      bad_par = (i == 2) ? 1'b1 : (i < 2 || i == 7) ? 1'b0 : (rnd8() > 8'hC0);
      k0 = n_sel;
      sel_db = ids;
      sel_go = 1'b1;
      tick(1);
      sel_go = 1'b0;
      for (k = 0; k < 900 && mdone !== 1'b1; k++) tick(1);
      tick(6);
      chk((n_sel - k0 == 1) === exp_sel(ids, bad_par), "selection answer wrong");
      if (connected === 1'b1) begin
        chk(sel_ids === ids, "captured ids wrong");
        tx_byte = rnd8();
        phase_in = 3'b001;
        // let the phase lines load first, so they frame the strobe and db is driven
        tick(1);
        for (k = 0; k < 20 && req_ready !== 1'b1; k++) tick(1);
        req_go = 1'b1;
        tick(1);
        req_go = 1'b0;
        for (k = 0; k < 20 && bus.req !== 1'b1; k++) tick(1);
        chk(bus.db === tx_byte && bus.dbp === ~^tx_byte && bus.sel === 1'b0, "bad strobe");
        for (k = 0; k < 40 && bus.req === 1'b1; k++) tick(1);
        // two timed strobes back to back: length, low time and edge spacing
        sync_en = 1'b1;
        req_go = 1'b1;
        for (k = 0; k < 60 && bus.req !== 1'b1; k++) tick(1);
        for (k = 0; k < 60 && bus.req === 1'b1; k++) tick(1);
        chk(k == ASSERT_CYC, "sync strobe length");
        for (k0 = 0; k0 < 60 && bus.req !== 1'b1; k0++) tick(1);
        req_go = 1'b0;
        chk(k0 >= NEG_CYC && k + k0 >= 18 && k + k0 <= 20, "sync strobe spacing");
        for (k = 0; k < 40 && bus.req === 1'b1; k++) tick(1);
        sync_en = 1'b0;
        resel_req = (i == 7);
        disc_req = 1'b1;
        for (k = 0; k < 60 && bus.bsy === 1'b1; k++) tick(1);
        disc_req = 1'b0;
        tick(120);
        chk(t_oe === '0, "lines held after bus free");
      end
      if (i < 7) tick(20);
    end
    note("selection");
    // reselection right after a clean disconnect
    for (k = 120; k < 800 && t_oe.bsy !== 1'b1; k++) tick(1);
    chk(k >= DISC && k < DISC + 160, "arbitration too soon or late");
    chk(bus.db[2] === 1'b1 && bus.sel === 1'b0, "own id missing in arbitration");
    for (k = 0; k < 400 && t_oe.sel !== 1'b1; k++) tick(1);
    chk(k >= 239, "arbitration sampled early");
    k0 = n_ok;
    for (k = 0; k < 600 && n_ok == k0; k++) tick(1);
    resel_req = 1'b0;
    tick(3);
    chk(n_ok == k0 + 1 && connected === 1'b1, "reselection not done");
    err_drop = 1'b1;
    tick(1);
    err_drop = 1'b0;
    tick(6);
    chk(n_abort == 1 && t_oe.bsy === 1'b0, "error drop");
    note("reselection");
    // lose to a higher id that shows up with our own busy
    tick(20);
    resel_req = 1'b1;
    for (k = 0; k < 400 && t_oe.bsy !== 1'b1; k++) tick(1);
    x_drv.bsy = 1'b1;
    x_drv.db[7] = 1'b1;
    k0 = n_lost;
    for (k = 0; k < 400 && n_lost == k0; k++) tick(1);
    resel_req = 1'b0;
    chk(n_lost == k0 + 1 && k >= 235, "arbitration loss");
    tick(5);
    chk(t_oe === '0, "loser holds lines");
    x_drv = '0;
    // another device raises select while we arbitrate
    tick(45);
    resel_req = 1'b1;
    for (k = 0; k < 400 && t_oe.bsy !== 1'b1; k++) tick(1);
    x_drv.sel = 1'b1;
    tick(4);
    chk(t_oe === '0, "select during arbitration ignored");
    resel_req = 1'b0;
    x_drv = '0;
    note("arbitration lost");
    // reselection with no answer from the initiator
    mute = 1'b1;
    tick(20);
    resel_req = 1'b1;
    k0 = n_fail;
    for (k = 0; k < 1500 && n_fail == k0; k++) tick(1);
    resel_req = 1'b0;
    tick(3);
    chk(n_fail == k0 + 1 && t_oe === '0, "reselection time-out");
    mute = 1'b0;
    note("time-out");
    // driven bus reset length
    tick(20);
    bus_reset_req = 1'b1;
    for (k = 0; k < 40 && t_oe.rst !== 1'b1; k++) tick(1);
    bus_reset_req = 1'b0;
    for (k = 0; k < 100 && t_oe.rst === 1'b1; k++) tick(1);
    chk(k >= 29 && k <= 31, "bus reset length");
    chk(rst_seen === 1'b1, "bus reset not reported");
    tick(3);
    chk(rst_seen === 1'b0, "bus reset report stuck");
    note("bus reset");
    summarize();
  end
endmodule

`default_nettype wire
